// ---- rtl/wwdt_ctrl.sv ----
// Purpose: software control, status and window check of the windowed watchdog
// Assumes: apb slave, zero wait states; configuration fields steady after reset
// Notes: reset and wake requests are one-cycle pulses for the system reset logic
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_regs.svh"

// Summary of operation
// R1: prescale codes 0 to 18 give ratio 32 doubling per code, up to 2^23.
// R2: prescale codes 19 to 31 act as the shortest timeout.
// R3: default prescale code is 11, ratio 65536, about two seconds.
// R4: at reset prescale loads 11 if config default is 31, else that default.
// R5: prescale field is read-only when config default is not 31.
// R6: software enable matters only in mode 01; resets to 0.
// R7: clock select 000 picks low oscillator, 001 mid oscillator; others reserved.
// R8: clock select resets to 000 if config is 111, else read-only.
// R9: window select loads config default; read-only unless that default is 111.
// R10: window code n opens (n+1) eighths of the period.
// R11: window open when timer is at least four times (7 minus code).
// R12: timer register bit 2 shows armed status.
// R13: 18-bit prescale counter split over low, high and timer registers.
// R14: prescale byte registers are read-only and zero after reset.
// R15: timer register read-only, zero at reset, bits 7:3 hold window timer.
// R16: intervals derive from the low oscillator divided by the ratio, or from the mid oscillator when clock select is 001.
// R17: mode 11 always on, 10 off in sleep, 01 software, 00 off.
// R18: reading control zero arms; clear while unarmed is a violation unless window code is 111.
// R19: clear while window closed is a violation and resets like a timeout.
// R20: any write to either control register clears counter and timer; writes with pstrb[0] low are ignored and do not clear.
// R21: prescaler and timer form one chained counter timing out at terminal.
// R22: counter register reads return live state without side effects.
module wwdt_ctrl
  import wwdt_pkg::*;
#(
  parameter int LFO_DIV = `WWDT_PCLK_HZ / `WWDT_LFO_HZ,
  parameter int MFO_DIV = `WWDT_PCLK_HZ / `WWDT_MFO_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WWDT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic [4:0] config_prescale_default,
  input wire logic [2:0] config_clock_default,
  input wire logic [2:0] config_window_default,
  input wire logic sleep_mode,
  input wire logic watchdog_clear_instruction,
  output logic watchdog_active,
  output logic window_open,
  output logic window_violation,
  output logic wdt_reset,
  output logic wdt_wake
);
  logic init_q;
  wwdt_ps_t ps_q;
  logic sen_q;
  logic [2:0] cs_q;
  logic [2:0] win_q;
  logic armed_q;
  logic sleep_q;
  logic [31:0] prdata_q;
  logic viol_q;
  logic reset_q;
  logic wake_q;
  logic [17:0] prescale_v;
  logic [4:0] timer_v;
  logic timeout;
  logic tick;
  logic [11:0] reg_idx;
  logic aligned;
  logic hit;
  logic setup_rd;
  logic acc;
  logic acc_wr;
  logic acc_rd;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic rd_ctrl0;
  logic ps_wr_ok;
  logic cs_wr_ok;
  logic win_wr_ok;
  logic [4:0] pre_len;
  logic [4:0] open_at;
  logic clr_valid;
  logic clr_bad;
  logic sleep_edge;
  logic cnt_clear;
  logic [7:0] rd_byte;

  // ---- apb decode
  assign reg_idx = paddr[`WWDT_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);

  always_comb begin
    case (reg_idx)
      `WWDT_IDX_CTRL0,
      `WWDT_IDX_CTRL1,
      `WWDT_IDX_PSL,
      `WWDT_IDX_PSH,
      `WWDT_IDX_TMR: hit = aligned;
      default: hit = 1'b0;
    endcase
  end

  assign acc = psel && penable;
  assign acc_wr = acc && pwrite && hit && pstrb[0];
  assign acc_rd = acc && !pwrite && hit;
  assign setup_rd = psel && !penable && !pwrite;
  // counter registers ignore writes silently; only the control pair stores
  assign wr_ctrl0 = acc_wr && (reg_idx == `WWDT_IDX_CTRL0); // R14
  assign wr_ctrl1 = acc_wr && (reg_idx == `WWDT_IDX_CTRL1);
  assign rd_ctrl0 = acc_rd && (reg_idx == `WWDT_IDX_CTRL0);

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = prdata_q;

  always_comb begin
    case (reg_idx)
      `WWDT_IDX_CTRL0: rd_byte = {2'b00, ps_q, sen_q};
      `WWDT_IDX_CTRL1: rd_byte = {1'b0, cs_q, 1'b0, win_q};
      `WWDT_IDX_PSL: rd_byte = prescale_v[7:0]; // R13
      `WWDT_IDX_PSH: rd_byte = prescale_v[15:8]; // R13
      `WWDT_IDX_TMR: rd_byte = {timer_v, armed_q, prescale_v[17:16]}; // R12 R15
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_q <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000; // R22
    end
  end

  // ---- configuration locks
  assign ps_wr_ok = (config_prescale_default == `WWDT_PS_UNSET); // R5
  assign cs_wr_ok = (config_clock_default == `WWDT_CS_UNSET); // R8
  assign win_wr_ok = (config_window_default == `WWDT_WIN_UNSET); // R9

  // configuration is caught one edge after reset release, never in the reset branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= `WWDT_PS_RESET;
    end else if (!init_q) begin
      ps_q <= ps_wr_ok ? `WWDT_PS_RESET : config_prescale_default; // R3 R4
    end else if (wr_ctrl0 && ps_wr_ok) begin
      ps_q <= pwdata[`WWDT_PS_MSB:`WWDT_PS_LSB]; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q <= 1'b0;
    end else if (wr_ctrl0) begin
      sen_q <= pwdata[`WWDT_SEN_BIT]; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= `WWDT_CS_RESET;
    end else if (!init_q) begin
      cs_q <= cs_wr_ok ? `WWDT_CS_RESET : config_clock_default; // R8
    end else if (wr_ctrl1 && cs_wr_ok) begin
      cs_q <= pwdata[`WWDT_CS_MSB:`WWDT_CS_LSB]; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q <= `WWDT_WIN_FULL;
    end else if (!init_q) begin
      win_q <= config_window_default; // R9
    end else if (wr_ctrl1 && win_wr_ok) begin
      win_q <= pwdata[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
    end
  end

  // ---- operating mode
  always_comb begin
    case (wwdt_mode_e'(watchdog_mode_config))
      WWDT_MODE_ON: watchdog_active = 1'b1; // R17
      WWDT_MODE_NO_SLEEP: watchdog_active = !sleep_mode; // R17
      WWDT_MODE_SW: watchdog_active = sen_q; // R6
      default: watchdog_active = 1'b0;
    endcase
  end

  // ---- count chain
  assign pre_len = (ps_q > `WWDT_PS_MAX) ? 5'h00 : ps_q; // R1 R2

  wwdt_tick_gen #(
    .LFO_DIV(LFO_DIV), // R16
    .MFO_DIV(MFO_DIV)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(watchdog_active && init_q),
    .clk_sel(cs_q),
    .tick_q(tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_mode;
    end
  end

  assign sleep_edge = sleep_mode ^ sleep_q;

  // ---- window check
  assign open_at = {3'h7 - win_q, 2'b00};
  assign window_open = (timer_v >= open_at); // R10 R11
  // full window needs no arming; any narrower window does
  assign clr_valid = watchdog_active && watchdog_clear_instruction && window_open
                     && (armed_q || win_q == `WWDT_WIN_FULL); // R18
  assign clr_bad = watchdog_active && watchdog_clear_instruction && !clr_valid; // R18 R19

  assign cnt_clear = !init_q || !watchdog_active || wr_ctrl0 || wr_ctrl1 || clr_valid
                     || clr_bad || sleep_edge; // R20

  wwdt_counter #(
    .PRE_W(18),
    .TMR_W(5)
  ) u_count (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .clear(cnt_clear),
    .pre_len(pre_len),
    .prescale_q(prescale_v),
    .timer_q(timer_v),
    .timeout_q(timeout)
  );

  // reading control zero arms; the arm wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (rd_ctrl0) begin
      armed_q <= 1'b1; // R18
    end else if (watchdog_clear_instruction) begin
      armed_q <= 1'b0;
    end
  end

  // ---- reset and wake requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_q <= 1'b0;
      reset_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      viol_q <= clr_bad; // R19
      reset_q <= clr_bad || (timeout && !sleep_mode); // R19
      wake_q <= timeout && sleep_mode;
    end
  end

  assign window_violation = viol_q;
  assign wdt_reset = reset_q;
  assign wdt_wake = wake_q;

  // ---- checks
  ps_lock_a: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    (init_q && wr_ctrl0 && !ps_wr_ok) |=> $stable(ps_q))
    else $error("locked prescale field changed on write");

  cs_lock_a: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (init_q && wr_ctrl1 && !cs_wr_ok) |=> $stable(cs_q))
    else $error("locked clock select changed on write");

  win_lock_a: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    (init_q && wr_ctrl1 && !win_wr_ok) |=> $stable(win_q))
    else $error("locked window select changed on write");

  init_load_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    !init_q |=> (ps_q == ($past(ps_wr_ok) ? `WWDT_PS_RESET : $past(config_prescale_default))))
    else $error("prescale not loaded from configuration");

  mode_gate_a: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    ((watchdog_mode_config == 2'b01 && init_q) |-> (watchdog_active == sen_q))
      and ((watchdog_mode_config == 2'b00) |-> !watchdog_active))
    else $error("software enable gating wrong");

  ps_decode_a: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (ps_q > 5'h12) |-> (pre_len == 5'h00))
    else $error("reserved prescale not minimum");

  win_open_a: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    ((win_q == 3'h6 && timer_v == 5'h04) |-> window_open)
      and ((win_q == 3'h0 && timer_v == 5'h1b) |-> !window_open))
    else $error("window edge misplaced");

  arm_set_a: assert property ( // R18
    @(posedge pclk) disable iff (!presetn)
    rd_ctrl0 |=> armed_q ##1 (armed_q || $past(watchdog_clear_instruction)))
    else $error("read of control zero did not arm");

  violation_a: assert property ( // R19
    @(posedge pclk) disable iff (!presetn)
    (watchdog_active && watchdog_clear_instruction && !window_open) |=> (wdt_reset && window_violation))
    else $error("closed-window clear gave no reset");

  wr_clear_a: assert property ( // R20
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl0 || wr_ctrl1) |=> (prescale_v == 18'h0_0000 && timer_v == 5'h00))
    else $error("control write did not clear counter");

  tmr_read_a: assert property ( // R22
    @(posedge pclk) disable iff (!presetn)
    (setup_rd && hit && reg_idx == `WWDT_IDX_TMR)
      |=> (prdata[7:3] == $past(timer_v) && prdata[2] == $past(armed_q)))
    else $error("timer register read mismatch");
endmodule // wwdt_ctrl
`default_nettype wire

// ---- pkg/wwdt_regs.svh ----
// Purpose: register map, field layout, reset values and timing of the watchdog control block
// Assumes: apb byte address is four times the register index
// Notes: definitions only
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH
`define WWDT_IDX_CTRL0 12'h80c
`define WWDT_IDX_CTRL1 12'h80d
`define WWDT_IDX_PSL 12'h80e
`define WWDT_IDX_PSH 12'h80f
`define WWDT_IDX_TMR 12'h810
`define WWDT_ADDR_W 14
`define WWDT_SEN_BIT 0
`define WWDT_PS_LSB 1
`define WWDT_PS_MSB 5
`define WWDT_WIN_LSB 0
`define WWDT_WIN_MSB 2
`define WWDT_CS_LSB 4
`define WWDT_CS_MSB 6
`define WWDT_PS_RESET 5'h0b
`define WWDT_PS_UNSET 5'h1f
`define WWDT_PS_MAX 5'h12
`define WWDT_CS_UNSET 3'h7
`define WWDT_CS_RESET 3'h0
`define WWDT_WIN_UNSET 3'h7
`define WWDT_WIN_FULL 3'h7
`define WWDT_PCLK_HZ 250000000
`define WWDT_LFO_HZ 31000
`define WWDT_MFO_HZ 31250
`endif

// ---- pkg/wwdt_pkg.sv ----
// Purpose: types shared by the watchdog control block
// Assumes: nothing
// Notes: encodings match the configuration and clock select fields
package wwdt_pkg;
  typedef enum logic [1:0] {
    WWDT_MODE_OFF = 2'b00,
    WWDT_MODE_SW = 2'b01,
    WWDT_MODE_NO_SLEEP = 2'b10,
    WWDT_MODE_ON = 2'b11
  } wwdt_mode_e;
  typedef enum logic [2:0] {
    WWDT_CLK_LOW = 3'b000,
    WWDT_CLK_MID = 3'b001
  } wwdt_clk_e;
  typedef logic [4:0] wwdt_ps_t;
endpackage

// ---- rtl/wwdt_tick_gen.sv ----
// Purpose: oscillator tick enable for the watchdog count chain
// Assumes: one pclk domain; oscillators modelled as pclk dividers
// Notes: reserved selects run from the low oscillator
`timescale 1ns/1ns
`default_nettype none
module wwdt_tick_gen
  import wwdt_pkg::*;
#(
  parameter int LFO_DIV = 8064,
  parameter int MFO_DIV = 8000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  output logic tick_q
);
  logic [15:0] div_q;
  logic [15:0] limit;

  always_comb begin
    case (clk_sel)
      WWDT_CLK_MID: limit = 16'(MFO_DIV - 1);
      default: limit = 16'(LFO_DIV - 1);
    endcase
  end

  // a stopped watchdog restarts its divider so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (!run) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q >= limit) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule // wwdt_tick_gen
`default_nettype wire

// ---- rtl/wwdt_counter.sv ----
// Purpose: chained prescale counter and window timer
// Assumes: tick is a one-cycle enable
// Notes: prescale bits above the selected length stay zero
`timescale 1ns/1ns
`default_nettype none
module wwdt_counter
  import wwdt_pkg::*;
#(
  parameter int PRE_W = 18,
  parameter int TMR_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic [4:0] pre_len,
  output logic [PRE_W-1:0] prescale_q,
  output logic [TMR_W-1:0] timer_q,
  output logic timeout_q
);
  logic [PRE_W-1:0] mask;
  logic pre_term;
  logic tmr_term;

  for (genvar i = 0; i < PRE_W; i++) begin : g_mask
    assign mask[i] = (5'(i) < pre_len);
  end

  assign pre_term = ((prescale_q & mask) == mask);
  assign tmr_term = &timer_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= '0;
      timer_q <= '0;
      timeout_q <= 1'b0;
    end else if (clear) begin
      prescale_q <= '0;
      timer_q <= '0;
      timeout_q <= 1'b0;
    end else if (tick) begin
      timeout_q <= pre_term && tmr_term; // R21
      if (pre_term) begin
        prescale_q <= '0;
        timer_q <= timer_q + TMR_W'(1);
      end else begin
        prescale_q <= prescale_q + PRE_W'(1);
      end
    end else begin
      timeout_q <= 1'b0;
    end
  end

  term_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
    (tick && !clear && pre_term && tmr_term) |=> (timeout_q && timer_q == '0))
    else $error("terminal count did not raise timeout");
endmodule // wwdt_counter
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the windowed watchdog control block
// Assumes: zero wait state apb slave; oscillator dividers shrunk to 4 and 3 pclk cycles
// Notes: configuration fields only change while reset is held
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_regs.svh"
module tb_top
  import wwdt_pkg::*;
;
  localparam int LD = 4;
  localparam int MD = 3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`WWDT_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] mode = 2'b01;
  logic [4:0] cps = 5'h1f;
  logic [2:0] ccs = 3'h7;
  logic [2:0] cwin = 3'h7;
  logic sleep_mode = 1'b0;
  logic wclr = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, watchdog_active, window_open, window_violation, wdt_reset, wdt_wake;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  wwdt_ctrl #(.LFO_DIV(LD), .MFO_DIV(MD)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_mode_config(mode),
    .config_prescale_default(cps), .config_clock_default(ccs), .config_window_default(cwin),
    .sleep_mode(sleep_mode), .watchdog_clear_instruction(wclr), .watchdog_active(watchdog_active),
    .window_open(window_open), .window_violation(window_violation), .wdt_reset(wdt_reset),
    .wdt_wake(wdt_wake));

  always #2 pclk = ~pclk;

  // whole run needs about 3000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      results();
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered right after a rising edge; adds one idle cycle so back to back calls never collide
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    chk(what, rd, {24'h0, exp});
  endtask

  task automatic rst(input logic [1:0] m, input logic [4:0] ps, input logic [2:0] cs, input logic [2:0] w);
    presetn <= 1'b0;
    mode <= m;
    cps <= ps;
    ccs <= cs;
    cwin <= w;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic clr(input logic v);
    wclr <= 1'b1;
    @(posedge pclk);
    wclr <= 1'b0;
    @(negedge pclk);
    chk("violation", window_violation, v);
    chk("reset request", wdt_reset, v);
    @(posedge pclk);
  endtask

  task automatic wopen(output int n);
    n = 0;
    while (window_open !== 1'b1 && n < 1000) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
  endtask

  // timer register first: the control zero read below arms and would set bit 2
  task automatic t_regs;
    rdc(`WWDT_IDX_TMR, 8'h00, "tmr reset");
    rdc(`WWDT_IDX_CTRL0, 8'h16, "ctrl0 reset");
    rdc(`WWDT_IDX_CTRL1, 8'h07, "ctrl1 reset");
    rdc(`WWDT_IDX_PSL, 8'h00, "psl reset");
    rdc(`WWDT_IDX_PSH, 8'h00, "psh reset");
    apb(1'b1, `WWDT_IDX_CTRL0, 8'h03);
    rdc(`WWDT_IDX_CTRL0, 8'h03, "ctrl0 write");
    apb(1'b1, `WWDT_IDX_CTRL1, 8'hff);
    rdc(`WWDT_IDX_CTRL1, 8'h77, "ctrl1 write");
    apb(1'b0, 12'h811, 8'h00);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("done registers");
  endtask

  task automatic t_lock;
    rdc(`WWDT_IDX_CTRL0, 8'h0a, "ctrl0 config");
    rdc(`WWDT_IDX_CTRL1, 8'h13, "ctrl1 config");
    apb(1'b1, `WWDT_IDX_CTRL0, 8'hff);
    rdc(`WWDT_IDX_CTRL0, 8'h0b, "ctrl0 locked");
    apb(1'b1, `WWDT_IDX_CTRL1, 8'h00);
    rdc(`WWDT_IDX_CTRL1, 8'h13, "ctrl1 locked");
    $display("done locking");
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      rst(m[1:0], 5'h1f, 3'h7, 3'h7);
      apb(1'b1, `WWDT_IDX_CTRL0, 8'h17);
      @(negedge pclk);
      chk("active enabled", watchdog_active, m != 0);
      @(posedge pclk);
      apb(1'b1, `WWDT_IDX_CTRL0, 8'h16);
      sleep_mode <= 1'b1;
      @(negedge pclk);
      chk("active asleep", watchdog_active, m == 3);
      @(posedge pclk);
      sleep_mode <= 1'b0;
      @(negedge pclk);
      chk("active awake", watchdog_active, m[1]);
      @(posedge pclk);
    end
    $display("done modes");
  endtask

  // counts cycles from the clearing write to the timeout pulse
  task automatic tmo(input logic [7:0] c0, input logic [7:0] c1, input int e, input logic slp);
    int n;
    n = 0;
    sleep_mode <= slp;
    apb(1'b1, `WWDT_IDX_CTRL1, c1);
    apb(1'b1, `WWDT_IDX_CTRL0, c0);
    while (wdt_reset !== 1'b1 && wdt_wake !== 1'b1 && n < 4 * e) begin
      @(negedge pclk);
      n++;
    end
    chk("timeout length", n >= e - 2 * LD && n <= e + 2 * LD, 1'b1);
    chk("wake", wdt_wake, slp);
    chk("reset", wdt_reset, !slp);
    @(posedge pclk);
    sleep_mode <= 1'b0;
  endtask

  task automatic t_timeout;
    logic [4:0] c [5] = '{5'h00, 5'h01, 5'h03, 5'h13, 5'h1f};
    for (int i = 0; i < 5; i++) begin
      tmo({2'b00, c[i], 1'b0}, 8'h07, (32 << (c[i] > 18 ? 0 : c[i])) * LD, 1'b0);
    end
    tmo(8'h00, 8'h17, 32 * MD, 1'b0);
    tmo(8'h00, 8'h07, 32 * LD, 1'b1);
    $display("done timeouts");
  endtask

  task automatic t_window(input logic [2:0] w);
    int n;
    int e;
    e = 8 * (7 - w) * LD;
    apb(1'b1, `WWDT_IDX_CTRL1, {5'h00, w});
    apb(1'b1, `WWDT_IDX_CTRL0, 8'h02);
    apb(1'b0, `WWDT_IDX_CTRL0, 8'h00);
    clr(1'b1);
    wopen(n);
    chk("open delay", n >= e - 2 * LD && n <= e + 2 * LD, 1'b1);
    apb(1'b0, `WWDT_IDX_CTRL0, 8'h00);
    apb(1'b0, `WWDT_IDX_TMR, 8'h00);
    chk("armed", rd[2], 1'b1);
    chk("timer field", rd[7:3] >= 4 * (7 - w), 1'b1);
    clr(1'b0);
    apb(1'b0, `WWDT_IDX_TMR, 8'h00);
    chk("disarmed", rd[2], 1'b0);
    wopen(n);
    clr(1'b1);
    $display("done window %0d", w);
  endtask

  task automatic t_count;
    logic [31:0] a;
    apb(1'b1, `WWDT_IDX_CTRL1, 8'h07);
    apb(1'b1, `WWDT_IDX_CTRL0, 8'h24);
    repeat (100) @(posedge pclk);
    apb(1'b0, `WWDT_IDX_PSL, 8'h00);
    a = rd;
    chk("count level", a >= 20 && a <= 30, 1'b1);
    apb(1'b1, `WWDT_IDX_PSL, 8'hff);
    apb(1'b0, `WWDT_IDX_PSL, 8'h00);
    chk("live count", rd > a && rd < 8'hff, 1'b1);
    apb(1'b0, `WWDT_IDX_PSH, 8'h00);
    chk("high byte", rd, 32'h0);
    apb(1'b1, `WWDT_IDX_CTRL0, 8'h24);
    apb(1'b0, `WWDT_IDX_PSL, 8'h00);
    chk("cleared by write", rd <= 2, 1'b1);
    $display("done counter");
  endtask

  initial begin
    rst(2'b01, 5'h1f, 3'h7, 3'h7);
    t_regs();
    rst(2'b01, 5'h05, 3'h1, 3'h3);
    t_lock();
    t_modes();
    rst(2'b11, 5'h1f, 3'h7, 3'h7);
    t_timeout();
    t_window(3'h6);
    t_window(3'h3);
    t_window(3'h0);
    t_count();
    results();
  end
endmodule // tb_top
`default_nettype wire
